// file: src/mdr_defines.svh
// Purpose: offsets, field positions and reset values of the motion block
// Assumes: byte-wide register port, 8-bit addresses
// Notes:   included by the motion register module only
`ifndef MDR_DEFINES_SVH
`define MDR_DEFINES_SVH
`define MDR_Y_ACCEL_LOW_ADDR        8'h10
`define MDR_Y_ACCEL_HIGH_ADDR       8'h11
`define MDR_Z_ACCEL_LOW_ADDR        8'h12
`define MDR_Z_ACCEL_HIGH_ADDR       8'h13
`define MDR_TEMPERATURE_LOW_ADDR    8'h14
`define MDR_TEMPERATURE_HIGH_ADDR   8'h15
`define MDR_KEYED_RESET_ADDR        8'h1f
`define MDR_MOTION_LIMIT_LOW_ADDR   8'h20
`define MDR_MOTION_LIMIT_HIGH_ADDR  8'h21
`define MDR_MOTION_SAMPLE_COUNT_ADDR 8'h22
`define MDR_STILL_LIMIT_LOW_ADDR    8'h23
`define MDR_STILL_LIMIT_HIGH_ADDR   8'h24
`define MDR_STILL_COUNT_LOW_ADDR    8'h25
`define MDR_STILL_COUNT_HIGH_ADDR   8'h26
`define MDR_RESET_KEY               8'h52
`define MDR_REG_RESET               8'h00
`define MDR_READ_ZERO               8'h00
`define MDR_LIMIT_HIGH_BITS         3
`define MDR_SIGN_BIT                11
`endif

// file: src/mdr_pkg.sv
// Purpose: types of the motion detect register block
// Assumes: one clock, sample strobe in the same domain
// Notes:   all state lives in one packed struct
package mdr_pkg;
   // detection count state, one-hot
   typedef enum logic [1:0]
   {
      MDR_ST_IDLE  = 2'b01,  // no sample strobe since reset
      MDR_ST_ARMED = 2'b10   // detection running
   } mdr_state_t;

   // whole module state
   typedef struct packed
   {
      mdr_state_t  state;
      logic [11:0] y_data;
      logic [11:0] z_data;
      logic [11:0] temp_data;
      logic [7:0]  motion_limit_low;
      logic [7:0]  motion_limit_high;
      logic [7:0]  motion_sample_count;
      logic [7:0]  still_limit_low;
      logic [7:0]  still_limit_high;
      logic [7:0]  still_count_low;
      logic [7:0]  still_count_high;
      logic [7:0]  motion_run;
      logic [15:0] still_run;
      logic        motion_flag;
      logic        still_flag;
      logic [7:0]  rd_data;
      logic        irq_oe;
      logic        standby;
   } mdr_regs_t;
endpackage

// file: src/mdr_motion_regs.sv
// Purpose: register file and activity/inactivity detection
// Assumes: host port is byte wide with one-cycle read and write strobes
// Notes:   detection advances on each sample strobe only
`timescale 1ns/1ps
`include "mdr_defines.svh"

// Operation
// - y result split into low/high bytes
// - z result split into low/high bytes
// - temperature result split into low/high bytes
// - upper nibble copies bit eleven
// - key write clears settings, enters standby
// - soft reset floats interrupt pins
// - keyed reset register reads zero
// - activity compares axis magnitude with limit
// - activity limit: eight low, three high
// - activity after consecutive over-limit samples
// - activity count zero acts as one
// - wake-up mode uses a single sample
// - inactivity compares axis magnitude with limit
// - inactivity limit: eight low, three high
// - inactivity after consecutive under-limit samples
// - inactivity count reaches full sixteen bits
// - inactivity count zero acts as one
// - activity sets motion flag
// - inactivity sets still flag
// - activity runs only when enabled
module mdr_motion_regs
   import mdr_pkg::*;
(
   input  wire logic        sys_clk_i,        // 50 MHz system clock
   input  wire logic        reset_i,          // async, active high
   input  wire logic [7:0]  reg_addr_i,       // register address
   input  wire logic        reg_wr_i,         // write strobe
   input  wire logic [7:0]  reg_wdata_i,      // write data
   input  wire logic        reg_rd_i,         // read strobe
   input  wire logic        sample_valid_i,   // new sample strobe
   input  wire logic [11:0] y_sample_i,       // signed y sample
   input  wire logic [11:0] z_sample_i,       // signed z sample
   input  wire logic [11:0] temp_sample_i,    // signed temperature
   input  wire logic        motion_detect_on_i, // activity enable
   input  wire logic        still_detect_on_i,  // inactivity enable
   input  wire logic        wake_mode_i,      // wake-up mode
   output logic [7:0]       reg_rdata_o,      // read data
   output logic             motion_flag_o,    // activity status
   output logic             still_flag_o,     // inactivity status
   output logic             irq_oe_o,         // interrupt pin drive
   output logic             standby_o         // standby after key
);

   // whole block state lives in one register
   mdr_regs_t s_r;    // registered state
   mdr_regs_t s_nxt;  // next state

   // detection helpers, all combinational; they work on the live
   // sample inputs, so the flags see the same values that the data
   // registers capture at that edge
   logic [10:0] motion_limit;  // assembled activity limit
   logic [10:0] still_limit;   // assembled inactivity limit
   logic [11:0] y_mag;         // |y|
   logic [11:0] z_mag;         // |z|
   logic        any_over;      // some axis above activity limit
   logic        all_under;     // every axis below inactivity limit
   logic [7:0]  motion_need;   // effective activity count
   logic [15:0] still_need;    // effective inactivity count
   logic [15:0] still_total;   // raw inactivity count

   // magnitude of a signed 12-bit code
   // -2048 gives 0x800, which still fits the unsigned result
   function automatic logic [11:0] mag12(input logic [11:0] v);
      mag12 = v[`MDR_SIGN_BIT] ? 12'((~v) + 12'h001) : v;
   endfunction

   // sign-extend a 12-bit value into the high byte
   function automatic logic [7:0] high_byte(input logic [11:0] v);
      high_byte = {{4{v[`MDR_SIGN_BIT]}}, v[11:8]};
   endfunction

   // limits, magnitudes and effective counts
   // only bits 2:0 of a high limit register count; the other bits
   // are kept for read-back and ignored here
   always_comb
   begin
      motion_limit = {s_r.motion_limit_high[`MDR_LIMIT_HIGH_BITS-1:0],
                      s_r.motion_limit_low};
      still_limit  = {s_r.still_limit_high[`MDR_LIMIT_HIGH_BITS-1:0],
                      s_r.still_limit_low};
      // axis magnitudes; temperature takes no part in detection
      y_mag = mag12(y_sample_i);
      z_mag = mag12(z_sample_i);
      // strict compare on magnitude against limit
      any_over  = (y_mag > {1'b0, motion_limit}) ||
                  (z_mag > {1'b0, motion_limit});
      all_under = (y_mag < {1'b0, still_limit}) &&
                  (z_mag < {1'b0, still_limit});
      // zero count behaves as one; wake mode forces one
      if (wake_mode_i || s_r.motion_sample_count == 8'h00)
      begin
         motion_need = 8'h01;
      end
      else
      begin
         motion_need = s_r.motion_sample_count;
      end
      // inactivity count from both bytes, zero behaves as one
      still_total = {s_r.still_count_high, s_r.still_count_low};
      still_need  = (still_total == 16'h0000) ? 16'h0001
                                              : still_total;
   end

   // next state: registers, detection, read mux
   always_comb
   begin
      s_nxt = s_r;
      // capture new sample results
      if (sample_valid_i)
      begin
         s_nxt.y_data    = y_sample_i;
         s_nxt.z_data    = z_sample_i;
         s_nxt.temp_data = temp_sample_i;
      end
      // detection on each sample strobe; a run counter counts
      // uninterrupted qualifying samples and restarts after it fires,
      // so a lasting condition fires again every N samples, while the
      // flag itself stays set until a key write or reset_i
      if (sample_valid_i)
      begin
         s_nxt.state = MDR_ST_ARMED;
         // activity run counter, advanced only on enabled
         // over-limit samples
         if (motion_detect_on_i && any_over)
         begin
            if (s_r.motion_run + 8'h01 >= motion_need)
            begin
               s_nxt.motion_flag = 1'b1;
               s_nxt.motion_run  = 8'h00;
            end
            else
            begin
               s_nxt.motion_run = s_r.motion_run + 8'h01;
            end
         end
         else
         begin
            s_nxt.motion_run = 8'h00;
         end
         // inactivity run counter, widened so 0xffff is reachable;
         // the compare runs one bit wider so a full count cannot wrap
         // the run counter before it matches
         if (still_detect_on_i && all_under)
         begin
            if (17'(s_r.still_run) + 17'h00001 >= 17'(still_need))
            begin
               s_nxt.still_flag = 1'b1;
               s_nxt.still_run  = 16'h0000;
            end
            else
            begin
               s_nxt.still_run = s_r.still_run + 16'h0001;
            end
         end
         else
         begin
            s_nxt.still_run = 16'h0000;
         end
      end
      // register reads, one cycle latency; zero whenever no read
      s_nxt.rd_data = `MDR_READ_ZERO;
      if (reg_rd_i)
      begin
         case (reg_addr_i)
            // y result, low byte
            `MDR_Y_ACCEL_LOW_ADDR:
            begin
               s_nxt.rd_data = s_r.y_data[7:0];
            end
            // y result, sign-extended high byte
            `MDR_Y_ACCEL_HIGH_ADDR:
            begin
               s_nxt.rd_data = high_byte(s_r.y_data);
            end
            // z result, low byte
            `MDR_Z_ACCEL_LOW_ADDR:
            begin
               s_nxt.rd_data = s_r.z_data[7:0];
            end
            // z result, sign-extended high byte
            `MDR_Z_ACCEL_HIGH_ADDR:
            begin
               s_nxt.rd_data = high_byte(s_r.z_data);
            end
            // temperature result, low byte
            `MDR_TEMPERATURE_LOW_ADDR:
            begin
               s_nxt.rd_data = s_r.temp_data[7:0];
            end
            // temperature result, sign-extended high byte
            `MDR_TEMPERATURE_HIGH_ADDR:
            begin
               s_nxt.rd_data = high_byte(s_r.temp_data);
            end
            // write-only key register
            `MDR_KEYED_RESET_ADDR:
            begin
               s_nxt.rd_data = `MDR_READ_ZERO;
            end
            // activity limit, low byte
            `MDR_MOTION_LIMIT_LOW_ADDR:
            begin
               s_nxt.rd_data = s_r.motion_limit_low;
            end
            // activity limit, high byte as written
            `MDR_MOTION_LIMIT_HIGH_ADDR:
            begin
               s_nxt.rd_data = s_r.motion_limit_high;
            end
            // activity sample count
            `MDR_MOTION_SAMPLE_COUNT_ADDR:
            begin
               s_nxt.rd_data = s_r.motion_sample_count;
            end
            // inactivity limit, low byte
            `MDR_STILL_LIMIT_LOW_ADDR:
            begin
               s_nxt.rd_data = s_r.still_limit_low;
            end
            // inactivity limit, high byte as written
            `MDR_STILL_LIMIT_HIGH_ADDR:
            begin
               s_nxt.rd_data = s_r.still_limit_high;
            end
            // inactivity count, low byte
            `MDR_STILL_COUNT_LOW_ADDR:
            begin
               s_nxt.rd_data = s_r.still_count_low;
            end
            // inactivity count, high byte
            `MDR_STILL_COUNT_HIGH_ADDR:
            begin
               s_nxt.rd_data = s_r.still_count_high;
            end
            // unmapped addresses read zero
            default:
            begin
               s_nxt.rd_data = `MDR_READ_ZERO;
            end
         endcase
      end
      // register writes; any setting write leaves standby
      if (reg_wr_i)
      begin
         case (reg_addr_i)
            // activity limit, low byte
            `MDR_MOTION_LIMIT_LOW_ADDR:
            begin
               s_nxt.motion_limit_low = reg_wdata_i;
            end
            // activity limit, high byte kept whole
            `MDR_MOTION_LIMIT_HIGH_ADDR:
            begin
               s_nxt.motion_limit_high = reg_wdata_i;
            end
            // activity sample count
            `MDR_MOTION_SAMPLE_COUNT_ADDR:
            begin
               s_nxt.motion_sample_count = reg_wdata_i;
            end
            // inactivity limit, low byte
            `MDR_STILL_LIMIT_LOW_ADDR:
            begin
               s_nxt.still_limit_low = reg_wdata_i;
            end
            // inactivity limit, high byte kept whole
            `MDR_STILL_LIMIT_HIGH_ADDR:
            begin
               s_nxt.still_limit_high = reg_wdata_i;
            end
            // inactivity count, low byte
            `MDR_STILL_COUNT_LOW_ADDR:
            begin
               s_nxt.still_count_low = reg_wdata_i;
            end
            // inactivity count, high byte
            `MDR_STILL_COUNT_HIGH_ADDR:
            begin
               s_nxt.still_count_high = reg_wdata_i;
            end
            // data, key and unmapped addresses hold all settings
            default:
            begin
               s_nxt.standby = s_r.standby;
            end
         endcase
         // any write other than to the key register counts as
         // configuration: leave standby and drive the interrupt pins
         if (reg_addr_i != `MDR_KEYED_RESET_ADDR)
         begin
            s_nxt.standby = 1'b0;
            s_nxt.irq_oe  = 1'b1;  // pins driven once configured
         end
      end
      // keyed soft reset overrides everything else; a sample or a
      // flag set in the same cycle is lost, since the key acts as a
      // reset of the whole block rather than as a flag clear
      if (reg_wr_i && reg_addr_i == `MDR_KEYED_RESET_ADDR &&
          reg_wdata_i == `MDR_RESET_KEY)
      begin
         s_nxt = '0;
         s_nxt.state   = MDR_ST_IDLE;
         s_nxt.standby = 1'b1;
         s_nxt.irq_oe  = 1'b0;
      end
      // state sanity; state marks a sample seen since the last reset
      case (s_nxt.state)
         MDR_ST_IDLE:  s_nxt.state = s_nxt.state;
         MDR_ST_ARMED: s_nxt.state = s_nxt.state;
         default:      s_nxt.state = MDR_ST_IDLE;
      endcase
   end

   // state register
   // async reset loads constants only: standby set, interrupt pins
   // floating, flags and settings cleared
   always_ff @(posedge sys_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         s_r         <= '0;
         s_r.state   <= MDR_ST_IDLE;
         s_r.standby <= 1'b1;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   // outputs straight from flops
   // no logic between the state register and the pins
   assign reg_rdata_o   = s_r.rd_data;
   assign motion_flag_o = s_r.motion_flag;
   assign still_flag_o  = s_r.still_flag;
   assign irq_oe_o      = s_r.irq_oe;
   assign standby_o     = s_r.standby;

endmodule // mdr_motion_regs

// file: testbench/mdr_motion_regs_sva.sv
// Purpose: port assertions of the motion register block
// Assumes: one clock, async active-high reset
// Notes:   bound to the block from the bench top file
`timescale 1ns/1ps
module mdr_motion_regs_sva
(
   input wire logic        sys_clk_i, reset_i, reg_wr_i, reg_rd_i,
   input wire logic        sample_valid_i, motion_detect_on_i,
   input wire logic        still_detect_on_i, wake_mode_i,
   input wire logic [7:0]  reg_addr_i, reg_wdata_i, reg_rdata_o,
   input wire logic [11:0] y_sample_i, z_sample_i, temp_sample_i,
   input wire logic        motion_flag_o, still_flag_o, irq_oe_o, standby_o
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (reset_i);
   logic key_w; // keyed reset write this cycle
   assign key_w = reg_wr_i && reg_addr_i == 8'h1f && reg_wdata_i == 8'h52;
   // read of an upper data byte
   sequence s_hi_rd;
      reg_rd_i && reg_addr_i inside {8'h11, 8'h13, 8'h15};
   endsequence
   // wrong key while awake
   sequence s_bad_key;
      reg_wr_i && reg_addr_i == 8'h1f && reg_wdata_i != 8'h52 && !standby_o;
   endsequence
   a_key_clears: assert property (
      key_w |=> standby_o && !irq_oe_o && !motion_flag_o && !still_flag_o)
      else $error("keyed reset left state behind");
   a_bad_key_kept: assert property (s_bad_key |=> !standby_o)
      else $error("wrong key caused standby");
   a_keyed_reads_zero: assert property (
      reg_rd_i && reg_addr_i == 8'h1f |=> reg_rdata_o == 8'h00)
      else $error("keyed register read not zero");
   a_idle_read_zero: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
      else $error("read data without a read");
   a_sign_copy: assert property (
      s_hi_rd |=> reg_rdata_o[7:4] == {4{reg_rdata_o[3]}})
      else $error("upper nibble not sign copy");
   a_motion_sticky: assert property (
      motion_flag_o && !key_w |=> motion_flag_o)
      else $error("motion flag dropped");
   a_still_sticky: assert property (
      still_flag_o && !key_w |=> still_flag_o)
      else $error("still flag dropped");
   a_motion_cause: assert property (
      $rose(motion_flag_o) |->
         $past(sample_valid_i) && $past(motion_detect_on_i))
      else $error("motion flag without enabled sample");
   a_still_cause: assert property (
      $rose(still_flag_o) |->
         $past(sample_valid_i) && $past(still_detect_on_i))
      else $error("still flag without enabled sample");
endmodule // mdr_motion_regs_sva

// file: testbench/mdr_host.sv
// Purpose: host model driving the byte register port
// Assumes: one access per call, strobe held across one rising edge
// Notes:   released address and data lines show the inverse of the last value
`timescale 1ns/1ps
module mdr_host
(
   input  wire logic       sys_clk_i,  // block clock
   output logic      [7:0] reg_addr_o, // register address
   output logic            reg_wr_o,   // write strobe
   output logic      [7:0] reg_wdata_o,// write data
   output logic            reg_rd_o    // read strobe
);
   // idle bus at time zero
   initial {reg_addr_o, reg_wr_o, reg_wdata_o, reg_rd_o} = '0;
   // one access: drive after a falling edge, release after the next
   task automatic access(input logic w, input logic [7:0] a, d);
      @(negedge sys_clk_i);
      reg_addr_o = a;
      reg_wdata_o = d;
      reg_wr_o = w;
      reg_rd_o = !w;
      @(negedge sys_clk_i);
      {reg_wr_o, reg_rd_o} = 2'b00;
      reg_addr_o = ~a;  // stale address must not matter
      reg_wdata_o = ~d;
   endtask
endmodule // mdr_host

// file: testbench/tb.sv
// Purpose: self-checking bench for the motion register block
// Assumes: host model owns the register port, bench owns samples
// Notes:   read answers are queued and compared by a monitor
`timescale 1ns/1ps
`define CHK(n, x, g) begin checked++; if ((g) !== (x)) begin \
   fail_count++; \
   $display("CHECK FAILED %s exp %h got %h", n, x, g); end end
module tb;
   logic        sys_clk_i, reset_i, sample_valid_i, rd_q;
   logic        motion_detect_on_i, still_detect_on_i, wake_mode_i;
   logic [11:0] y_sample_i, z_sample_i, temp_sample_i, m, v[3];
   logic [7:0]  reg_addr_i, reg_wdata_i, reg_rdata_o, exp_q[$], e, ex;
   logic        reg_wr_i, reg_rd_i, motion_flag_o, still_flag_o;
   logic        irq_oe_o, standby_o;
   logic [31:0] seed = 32'ha20b9c96;
   int          fail_count = 0, checked = 0, i;
   mdr_motion_regs mdr_motion_regs_i (.sys_clk_i, .reset_i, .reg_addr_i,
      .reg_wr_i, .reg_wdata_i, .reg_rd_i, .sample_valid_i, .y_sample_i,
      .z_sample_i, .temp_sample_i, .motion_detect_on_i, .still_detect_on_i,
      .wake_mode_i, .reg_rdata_o, .motion_flag_o, .still_flag_o, .irq_oe_o,
      .standby_o);
   mdr_host mdr_host_i (.sys_clk_i, .reg_addr_o(reg_addr_i),
      .reg_wr_o(reg_wr_i), .reg_wdata_o(reg_wdata_i), .reg_rd_o(reg_rd_i));
   // 50 MHz clock
   initial
   begin
      sys_clk_i = 1'b0;
      forever #10 sys_clk_i = ~sys_clk_i;
   end
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic wr(input logic [7:0] a, d);
      mdr_host_i.access(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, x);
      exp_q.push_back(x);
      mdr_host_i.access(1'b0, a, 8'h00);
   endtask
   // one sample strobe; flags settle before return
   task automatic smp(input logic [11:0] y, z, t);
      @(negedge sys_clk_i);
      {y_sample_i, z_sample_i, temp_sample_i} = {y, z, t};
      sample_valid_i = 1'b1;
      @(negedge sys_clk_i);
      sample_valid_i = 1'b0;
      {y_sample_i, z_sample_i} = {~y, ~z};
   endtask
   task automatic key();
      wr(8'h1f, 8'h52);
      `CHK("standby", 1'b1, standby_o)
      `CHK("irq_oe", 1'b0, irq_oe_o)
      rd(8'h22, 8'h00);
   endtask
   // random limit 1..1024, junk in the ignored high bits, then count
   task automatic cfg(input logic [7:0] b, c);
      m = {2'b00, 10'(xs())} + 12'd1;
      wr(b, m[7:0]);
      wr(b + 8'h01, {5'(xs()), m[10:8]});
      wr(b + 8'h02, c);
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // read answer stands one cycle after the read edge
   always @(posedge sys_clk_i) rd_q <= reg_rd_i;
   always @(negedge sys_clk_i)
      if (rd_q && exp_q.size() > 0)
      begin
         ex = exp_q.pop_front();
         `CHK("rdata", ex, reg_rdata_o)
      end
   // hang guard
   initial
   begin
      repeat (100000) @(posedge sys_clk_i);
      fail_count++;
      complete_run();
   end
   // main sequence
   initial
   begin
      {reset_i, sample_valid_i, wake_mode_i} = 3'b100;
      {motion_detect_on_i, still_detect_on_i} = 2'b00;
      {y_sample_i, z_sample_i, temp_sample_i} = '0;
      repeat (20) @(negedge sys_clk_i);
      reset_i = 1'b0;
      for (i = 8'h10; i <= 8'h30; i++)
         if (i < 8'h16 || (i > 8'h1e && i < 8'h27) || i == 8'h30)
            rd(8'(i), 8'h00);
      $display("reset values done");
      for (i = 8'h20; i <= 8'h26; i++)
      begin
         e = 8'(xs());
         wr(8'(i), e);
         rd(8'(i), e);
      end
      wr(8'h1f, 8'h51);
      `CHK("standby", 1'b0, standby_o)
      `CHK("irq_oe", 1'b1, irq_oe_o)
      rd(8'h1f, 8'h00);
      $display("register access done");
      for (i = 0; i < 4; i++)
      begin
         foreach (v[j]) v[j] = 12'(xs());
         smp(v[0], v[1], v[2]);
         foreach (v[j])
         begin
            rd(8'h10 + 8'(2 * j), v[j][7:0]);
            rd(8'h11 + 8'(2 * j), {{4{v[j][11]}}, v[j][11:8]});
         end
      end
      $display("sample data done");
      key();
      cfg(8'h20, 8'h03);
      motion_detect_on_i = 1'b1;
      for (i = 0; i < 6; i++)
      begin
         smp(i == 2 ? m : ~m, i == 2 ? -m : 12'h000, 12'h000);
         `CHK("motion", i == 5, motion_flag_o)
      end
      for (i = 0; i < 3; i++)
      begin
         key();
         cfg(8'h20, i == 1 ? 8'h05 : 8'h00);
         wake_mode_i = (i == 1);
         motion_detect_on_i = (i != 2);
         smp(12'h000, ~m, 12'h000);
         `CHK("motion", i != 2, motion_flag_o)
      end
      $display("activity done");
      key();
      cfg(8'h23, 8'h01);
      wr(8'h26, 8'h01);
      still_detect_on_i = 1'b1;
      for (i = 0; i < 358; i++)
      begin
         smp(m - 12'd1, i == 100 ? m : 12'd1 - m, 12'h000);
         `CHK("still", i == 357, still_flag_o)
      end
      key();
      cfg(8'h23, 8'h00);
      smp(12'h000, 12'h000, 12'h000);
      `CHK("still", 1'b1, still_flag_o)
      $display("inactivity done");
      repeat (3) @(negedge sys_clk_i);
      complete_run();
   end
endmodule // tb
bind mdr_motion_regs mdr_motion_regs_sva mdr_motion_regs_sva_i (.sys_clk_i,
   .reset_i, .reg_wr_i, .reg_rd_i, .sample_valid_i, .motion_detect_on_i,
   .still_detect_on_i, .wake_mode_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o,
   .y_sample_i, .z_sample_i, .temp_sample_i, .motion_flag_o, .still_flag_o,
   .irq_oe_o, .standby_o);
